//--- dbgrs_top.sv
// Purpose: Device side of a two-wire debug port register select
// Assumes: Link clock sampled by i_clk, well below half its rate
// Notes:   Frame = start 0, 2 instruction bits, 8 data bits LSB first
`include "dbgrs_params.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Two pins: clock input, shared data line
// - Select write stores, steers data accesses
// - Select 0x00 reads fixed part identifier
// - Select 0x01 reads silicon revision code
// - Select 0x02 accesses halt control
// - Selects for program control, data, status
// - Selects for address high and low
// - Selects for checksum bytes zero to three
// - Select read returns status, bit7 busy
// - Checksum byte zero write starts checksum
// - Status shows error and lock flags
module dbgrs_top import dbgrs_pkg::*; #(
  parameter dbgrs_byte_t PART_ID     = 8'h5a, // Arbitrary value
  parameter dbgrs_byte_t REVISION    = 8'h3c, // Arbitrary value
  parameter int          TIMEOUT_CYC = `DBGRS_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Link pins
  input  wire logic        i_debug_clock_pin,
  input  wire logic        i_debug_data_pin,
  output logic             o_debug_data_pin,
  output logic             o_debug_data_pin_oe,
  // Code memory
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic      [15:0] o_mem_addr,
  output dbgrs_byte_t      o_mem_wdata,
  input  wire logic        i_mem_done,
  input  wire dbgrs_byte_t i_mem_rdata,
  input  wire logic        i_mem_denied,
  input  wire logic        i_write_locked,
  input  wire logic        i_read_locked,
  // Control outputs
  output dbgrs_byte_t      o_halt_control,
  output dbgrs_byte_t      o_prom_program_control
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]   pin_s;
  logic         ck_s;
  logic         dat_s;
  logic         ck_prev_q;
  logic         rise;
  logic         fall;
  dbgrs_state_t state_q;
  logic [2:0]   bitcnt_q;
  logic         ins0_q;
  logic [1:0]   ins_q;
  logic [1:0]   ins_full;
  dbgrs_byte_t  shift_q;
  dbgrs_byte_t  wr_byte;
  logic         rd_start;
  logic         wr_commit;
  logic         rd_commit;
  logic [15:0]  tmo_q;
  dbgrs_byte_t  sel_q;
  dbgrs_byte_t  data_q;
  logic [15:0]  addr_q;
  dbgrs_byte_t  chk_two_q;
  dbgrs_byte_t  chk_three_q;
  logic         err_q;
  logic         op_busy_q;
  logic         op_is_rd_q;
  logic         busy;
  logic         chk_start;
  logic         chk_req;
  logic [15:0]  chk_addr;
  logic         chk_busy;
  logic [15:0]  chk_result;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  function automatic dbgrs_byte_t read_value(input logic [1:0]  ins,
                                             input dbgrs_byte_t sel);
    dbgrs_byte_t v;
    v = 8'h00;
    if (ins == `DBGRS_INS_ADDR_RD) begin
      v[`DBGRS_BUSY_BIT] = busy;
    end else begin
      case (sel)
        `DBGRS_SEL_PART_ID:     v = PART_ID;
        `DBGRS_SEL_REVISION:    v = REVISION;
        `DBGRS_SEL_HALT:        v = o_halt_control;
        `DBGRS_SEL_PROG_CTRL:   v = o_prom_program_control;
        `DBGRS_SEL_DATA_PORT:   v = data_q;
        `DBGRS_SEL_PROM_STATUS: begin
          v[`DBGRS_WR_LOCK_BIT] = i_write_locked;
          v[`DBGRS_RD_LOCK_BIT] = i_read_locked;
          v[`DBGRS_ERROR_BIT]   = err_q;
        end
        `DBGRS_SEL_ADDR_HIGH:   v = addr_q[15:8];
        `DBGRS_SEL_ADDR_LOW:    v = addr_q[7:0];
        `DBGRS_SEL_CHK_ZERO:    v = chk_result[7:0];
        `DBGRS_SEL_CHK_ONE:     v = chk_result[15:8];
        `DBGRS_SEL_CHK_TWO:     v = chk_two_q;
        `DBGRS_SEL_CHK_THREE:   v = chk_three_q;
        default:                v = 8'h00;
      endcase
    end
    return v;
  endfunction : read_value

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and edges
  dbgrs_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async ({i_debug_clock_pin, i_debug_data_pin}),
    .o_sync  (pin_s)
  );

  assign ck_s  = pin_s[1];
  assign dat_s = pin_s[0];
  assign rise  = ck_s & ~ck_prev_q;
  assign fall  = ~ck_s & ck_prev_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ck_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing
  assign ins_full  = {dat_s, ins0_q};
  assign wr_byte   = {dat_s, shift_q[7:1]};
  assign rd_start  = (state_q == ST_INS) && rise && (bitcnt_q == 3'd1) &&
                     !ins_full[0];
  assign wr_commit = (state_q == ST_WDATA) && rise && (bitcnt_q == 3'd7);
  assign rd_commit = (state_q == ST_RDATA) && rise && (bitcnt_q == 3'd7);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q  <= ST_IDLE;
      bitcnt_q <= 3'd0;
      ins0_q   <= 1'b0;
      ins_q    <= 2'b00;
      shift_q  <= 8'h00;
    end else if (state_q != ST_IDLE && tmo_q >= 16'(TIMEOUT_CYC)) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (rise && !dat_s) begin
            state_q  <= ST_INS;
            bitcnt_q <= 3'd0;
          end
        end
        ST_INS: begin
          if (rise) begin
            ins0_q   <= dat_s;
            bitcnt_q <= bitcnt_q + 3'd1;
            if (bitcnt_q == 3'd1) begin
              ins_q    <= ins_full;
              bitcnt_q <= 3'd0;
              if (ins_full[0]) begin
                state_q <= ST_WDATA;
              end else begin
                state_q <= ST_RDATA;
                shift_q <= read_value(ins_full, sel_q);
              end
            end
          end
        end
        ST_WDATA: begin
          if (rise) begin
            shift_q  <= wr_byte;
            bitcnt_q <= bitcnt_q + 3'd1;
            if (bitcnt_q == 3'd7) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_RDATA: begin
          if (rise) begin
            shift_q  <= {1'b0, shift_q[7:1]};
            bitcnt_q <= bitcnt_q + 3'd1;
            if (bitcnt_q == 3'd7) begin
              state_q <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Abort a frame whose clock stalls
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tmo_q <= 16'h0000;
    end else if (state_q == ST_IDLE || rise || fall) begin
      tmo_q <= 16'h0000;
    end else begin
      tmo_q <= tmo_q + 16'h0001;
    end
  end

  // Data line drive, released after the last read bit
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_debug_data_pin    <= 1'b0;
      o_debug_data_pin_oe <= 1'b0;
    end else if (state_q != ST_RDATA || rd_commit) begin
      o_debug_data_pin_oe <= 1'b0;
    end else if (fall) begin
      o_debug_data_pin    <= shift_q[0];
      o_debug_data_pin_oe <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select and target registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sel_q <= `DBGRS_SEL_RESET;
    end else if (wr_commit && ins_q == `DBGRS_INS_ADDR_WR) begin
      sel_q <= wr_byte;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_halt_control         <= `DBGRS_BYTE_RESET;
      o_prom_program_control <= `DBGRS_BYTE_RESET;
      chk_two_q              <= `DBGRS_BYTE_RESET;
      chk_three_q            <= `DBGRS_BYTE_RESET;
    end else if (wr_commit && ins_q == `DBGRS_INS_DATA_WR) begin
      case (sel_q)
        `DBGRS_SEL_HALT:      o_halt_control <= wr_byte;
        `DBGRS_SEL_PROG_CTRL: o_prom_program_control <= wr_byte;
        `DBGRS_SEL_CHK_TWO:   chk_two_q <= wr_byte;
        `DBGRS_SEL_CHK_THREE: chk_three_q <= wr_byte;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory operations through the data port
  assign busy      = op_busy_q | chk_busy;
  assign chk_start = wr_commit && ins_q == `DBGRS_INS_DATA_WR &&
                     sel_q == `DBGRS_SEL_CHK_ZERO && !busy;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      op_busy_q   <= 1'b0;
      op_is_rd_q  <= 1'b0;
      addr_q      <= 16'h0000;
      data_q      <= `DBGRS_BYTE_RESET;
      err_q       <= 1'b0;
      o_mem_wr    <= 1'b0;
      o_mem_wdata <= `DBGRS_BYTE_RESET;
    end else begin
      o_mem_wr <= 1'b0;
      if (op_busy_q && i_mem_done) begin
        op_busy_q <= 1'b0;
        err_q     <= i_mem_denied;
        addr_q    <= addr_q + 16'h0001;
        if (op_is_rd_q) begin
          data_q <= i_mem_rdata;
        end
      end else if (wr_commit && ins_q == `DBGRS_INS_DATA_WR) begin
        if (sel_q == `DBGRS_SEL_ADDR_HIGH) begin
          addr_q[15:8] <= wr_byte;
        end else if (sel_q == `DBGRS_SEL_ADDR_LOW) begin
          addr_q[7:0] <= wr_byte;
        end else if (sel_q == `DBGRS_SEL_DATA_PORT && !busy) begin
          op_busy_q   <= 1'b1;
          op_is_rd_q  <= 1'b0;
          o_mem_wr    <= 1'b1;
          o_mem_wdata <= wr_byte;
        end
      end else if (rd_commit && ins_q == `DBGRS_INS_DATA_RD &&
                   sel_q == `DBGRS_SEL_DATA_PORT && !busy) begin
        op_busy_q  <= 1'b1;
        op_is_rd_q <= 1'b1;
      end
    end
  end

  // Shared memory request lines
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_mem_rd   <= 1'b0;
      o_mem_addr <= 16'h0000;
    end else begin
      o_mem_rd   <= chk_req | (rd_commit && ins_q == `DBGRS_INS_DATA_RD &&
                    sel_q == `DBGRS_SEL_DATA_PORT && !busy);
      o_mem_addr <= chk_busy ? chk_addr : addr_q;
    end
  end

  dbgrs_checksum u_checksum (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_start     (chk_start),
    .i_block     (wr_byte),
    .i_mem_done  (i_mem_done & chk_busy),
    .i_mem_rdata (i_mem_rdata),
    .o_rd_req    (chk_req),
    .o_rd_addr   (chk_addr),
    .o_busy      (chk_busy),
    .o_result    (chk_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_rd_sel(dbgrs_byte_t s);
    rd_start && ins_full == `DBGRS_INS_DATA_RD && sel_q == s;
  endsequence

  sequence s_data_wr(dbgrs_byte_t s);
    wr_commit && ins_q == `DBGRS_INS_DATA_WR && sel_q == s;
  endsequence

  property p_sel_write;
    (wr_commit && ins_q == `DBGRS_INS_ADDR_WR) |=>
      sel_q == $past(wr_byte) && state_q == ST_IDLE;
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select not stored");

  property p_part_id;
    s_rd_sel(`DBGRS_SEL_PART_ID) |=> shift_q == PART_ID;
  endproperty
  a_part_id: assert property (p_part_id)
    else $error("part identifier wrong");

  property p_revision;
    s_rd_sel(`DBGRS_SEL_REVISION) |=> shift_q == REVISION;
  endproperty
  a_revision: assert property (p_revision)
    else $error("revision wrong");

  property p_halt;
    s_data_wr(`DBGRS_SEL_HALT) |=> o_halt_control == $past(wr_byte);
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt control not written");

  property p_addr_low;
    s_data_wr(`DBGRS_SEL_ADDR_LOW) ##0 !op_busy_q |=>
      addr_q[7:0] == $past(wr_byte) && $stable(addr_q[15:8]);
  endproperty
  a_addr_low: assert property (p_addr_low)
    else $error("address low not written");

  property p_status;
    (rd_start && ins_full == `DBGRS_INS_ADDR_RD) |=>
      shift_q == {$past(busy), 7'h00};
  endproperty
  a_status: assert property (p_status)
    else $error("status byte wrong");

  property p_chk_start;
    chk_start |=> chk_busy ##1 o_mem_rd;
  endproperty
  a_chk_start: assert property (p_chk_start)
    else $error("checksum did not start");

  property p_error;
    (op_busy_q && i_mem_done) |=> err_q == $past(i_mem_denied) && !busy;
  endproperty
  a_error: assert property (p_error)
    else $error("error flag wrong");

  property p_release;
    rd_commit |=> !o_debug_data_pin_oe [*2];
  endproperty
  a_release: assert property (p_release)
    else $error("data line not released");

  property p_unlisted;
    s_rd_sel(8'h55) |=> shift_q == 8'h00;
  endproperty
  a_unlisted: assert property (p_unlisted)
    else $error("unlisted select read not zero");

endmodule : dbgrs_top

`default_nettype wire

//--- dbgrs_params.svh
// Purpose: Constants of the debug port register-select block
// Assumes: 40 MHz core clock
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef DBGRS_PARAMS_SVH
`define DBGRS_PARAMS_SVH

// Select values
`define DBGRS_SEL_PART_ID     8'h00
`define DBGRS_SEL_REVISION    8'h01
`define DBGRS_SEL_HALT        8'h02
`define DBGRS_SEL_PROG_CTRL   8'hdf
`define DBGRS_SEL_DATA_PORT   8'hbf
`define DBGRS_SEL_PROM_STATUS 8'hb7
`define DBGRS_SEL_ADDR_HIGH   8'haf
`define DBGRS_SEL_ADDR_LOW    8'hae
`define DBGRS_SEL_CHK_ZERO    8'ha9
`define DBGRS_SEL_CHK_ONE     8'haa
`define DBGRS_SEL_CHK_TWO     8'hab
`define DBGRS_SEL_CHK_THREE   8'hac

// Reset values, checksum seed and polynomial
`define DBGRS_SEL_RESET       8'h00
`define DBGRS_BYTE_RESET      8'h00
`define DBGRS_CHK_INIT        16'hffff
`define DBGRS_CHK_POLY        16'h1021

// Field positions
`define DBGRS_BUSY_BIT        7
`define DBGRS_WR_LOCK_BIT     7
`define DBGRS_RD_LOCK_BIT     6
`define DBGRS_ERROR_BIT       0

// Frame instruction codes, first bit is bit 0
`define DBGRS_INS_DATA_RD     2'b00
`define DBGRS_INS_DATA_WR     2'b01
`define DBGRS_INS_ADDR_RD     2'b10
`define DBGRS_INS_ADDR_WR     2'b11

// Timing
`define DBGRS_CLK_PERIOD_NS   25
`define DBGRS_TIMEOUT_NS      20000
`define DBGRS_TIMEOUT_CYC     (`DBGRS_TIMEOUT_NS / `DBGRS_CLK_PERIOD_NS)

`endif

//--- dbgrs_pkg.sv
// Purpose: Types of the debug port register-select block
// Assumes: Nothing
// Notes:   Constants live in dbgrs_params.svh
`default_nettype none

package dbgrs_pkg;

  typedef logic [7:0] dbgrs_byte_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INS   = 4'b0010,
    ST_WDATA = 4'b0100,
    ST_RDATA = 4'b1000
  } dbgrs_state_t;

endpackage : dbgrs_pkg

`default_nettype wire

//--- dbgrs_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are levels from outside the clock domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module dbgrs_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : dbgrs_sync

`default_nettype wire

//--- dbgrs_checksum.sv
// Purpose: 16-bit checksum over one 256-byte code-memory block
// Assumes: Memory answers each read with one i_mem_done pulse
// Notes:   Block starts at upper byte given, lower byte zero
`include "dbgrs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dbgrs_checksum import dbgrs_pkg::*; #(
  parameter logic [15:0] POLY = `DBGRS_CHK_POLY,
  parameter logic [15:0] INIT = `DBGRS_CHK_INIT
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Control
  input  wire logic        i_start,
  input  wire dbgrs_byte_t i_block,
  // Memory
  input  wire logic        i_mem_done,
  input  wire dbgrs_byte_t i_mem_rdata,
  output logic             o_rd_req,
  output logic      [15:0] o_rd_addr,
  // Result
  output logic             o_busy,
  output logic      [15:0] o_result
);

  function automatic logic [15:0] chk_step(input logic [15:0] crc,
                                           input dbgrs_byte_t data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ POLY) : (c << 1);
    end
    return c;
  endfunction : chk_step

  // Walk the block one byte at a time
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_busy    <= 1'b0;
      o_rd_req  <= 1'b0;
      o_rd_addr <= 16'h0000;
      o_result  <= 16'h0000;
    end else begin
      o_rd_req <= 1'b0;
      if (i_start && !o_busy) begin
        o_busy    <= 1'b1;
        o_rd_req  <= 1'b1;
        o_rd_addr <= {i_block, 8'h00};
        o_result  <= INIT;
      end else if (o_busy && i_mem_done) begin
        o_result <= chk_step(o_result, i_mem_rdata);
        if (o_rd_addr[7:0] == 8'hff) begin
          o_busy <= 1'b0;
        end else begin
          o_rd_addr <= o_rd_addr + 16'h0001;
          o_rd_req  <= 1'b1;
        end
      end
    end
  end

endmodule : dbgrs_checksum

`default_nettype wire

//--- dbgrs_adapter.sv
// Purpose: Model of the external programming and debug adapter
// Assumes: Device samples the link clock with a 40 MHz core clock
// Notes:   Link half period 4 core cycles, 100 ns; pull-up on data line
`include "dbgrs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dbgrs_adapter import dbgrs_pkg::*; (
  // Clock
  input  wire logic  i_clk,
  // Resolved data line
  input  wire logic  i_line,
  // Link pins
  output logic       o_clk_pin,
  output logic       o_data,
  output logic       o_oe,
  // Read result
  output logic       o_rvalid,
  output dbgrs_byte_t o_rdata
);
  initial begin
    o_clk_pin = 1'b0;
    o_data    = 1'b1;
    o_oe      = 1'b0;
    o_rvalid  = 1'b0;
    o_rdata   = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // One bit driven, clock stands low between bits
  task automatic bit_out(input logic b);
    o_data <= b;
    o_oe   <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_clk_pin <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_clk_pin <= 1'b0;
  endtask : bit_out

  // One bit read with line released, sampled just after the rise
  task automatic bit_in(output logic b);
    o_oe <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_clk_pin <= 1'b1;
    @(posedge i_clk);
    b = i_line;
    repeat (3) @(posedge i_clk);
    o_clk_pin <= 1'b0;
  endtask : bit_in

  ////////////////////////////////////////////////////////////////////////
  // Whole frame: start, instruction, eight data bits LSB first
  task automatic frame(input logic [1:0] ins, input dbgrs_byte_t wd);
    dbgrs_byte_t r;
    @(posedge i_clk);
    bit_out(1'b0);
    bit_out(ins[0]);
    bit_out(ins[1]);
    if (ins[0]) begin
      for (int i = 0; i < 8; i++) bit_out(wd[i]);
    end else begin
      for (int i = 0; i < 8; i++) bit_in(r[i]);
      o_rdata  <= r;
      o_rvalid <= 1'b1;
      @(posedge i_clk);
      o_rvalid <= 1'b0;
    end
    o_oe <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask : frame
endmodule : dbgrs_adapter
`default_nettype wire

//--- test_two_wire_debug_register_select.sv
// Purpose: Self-checking bench of the debug port register select
// Assumes: Adapter model drives the link, bench models code memory
// Notes:   Results noted in a queue, compared by a monitor process
`include "dbgrs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module test_two_wire_debug_register_select import dbgrs_pkg::*;;
  localparam dbgrs_byte_t PID = 8'h96; // Arbitrary value
  localparam dbgrs_byte_t REV = 8'h21; // Arbitrary value
  typedef struct {string n; dbgrs_byte_t v; dbgrs_byte_t m;} dbgrs_note_t;

  logic i_clk, i_reset, mem_done, mem_deny, wl, rl, deny_q;
  logic dut_d, dut_oe, adp_clk, adp_d, adp_oe, adp_rv, line, m_rd, m_wr;
  logic [15:0] m_addr, m_lat;
  logic [2:0] m_cnt;
  dbgrs_byte_t m_wdata, m_rdata, adp_rdata;
  int checks, failures;
  dbgrs_note_t q[$];
  logic [23:0] mq[$];

  assign line = dut_oe ? dut_d : (adp_oe ? adp_d : 1'b1);

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  dbgrs_top #(.PART_ID(PID), .REVISION(REV), .TIMEOUT_CYC(40)) dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_debug_clock_pin(adp_clk),
    .i_debug_data_pin(line), .o_debug_data_pin(dut_d),
    .o_debug_data_pin_oe(dut_oe), .o_mem_rd(m_rd), .o_mem_wr(m_wr),
    .o_mem_addr(m_addr), .o_mem_wdata(m_wdata), .i_mem_done(mem_done),
    .i_mem_rdata(m_rdata), .i_mem_denied(mem_deny),
    .i_write_locked(wl), .i_read_locked(rl),
    .o_halt_control(), .o_prom_program_control());

  dbgrs_adapter adp_u (.i_clk(i_clk), .i_line(line), .o_clk_pin(adp_clk),
    .o_data(adp_d), .o_oe(adp_oe), .o_rvalid(adp_rv), .o_rdata(adp_rdata));

  ////////////////////////////////////////////////////////////////////////
  // Memory contents and reference checksum
  function automatic dbgrs_byte_t mv(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5c;
  endfunction : mv

  function automatic logic [15:0] crc_ref(input dbgrs_byte_t b);
    logic [15:0] c;
    c = `DBGRS_CHK_INIT;
    for (int a = 0; a < 256; a++) begin
      c = c ^ {mv({b, 8'(a)}), 8'h00};
      for (int k = 0; k < 8; k++)
        c = c[15] ? ((c << 1) ^ `DBGRS_CHK_POLY) : (c << 1);
    end
    return c;
  endfunction : crc_ref

  // Memory answers after one to four cycles
  always @(posedge i_clk) begin
    mem_done <= 1'b0;
    mem_deny <= deny_q;
    if (m_rd || m_wr) begin
      m_cnt <= 3'(1 + $urandom % 4);
      m_lat <= m_addr;
    end else if (m_cnt != 3'd0) begin
      m_cnt <= m_cnt - 3'd1;
      if (m_cnt == 3'd1) begin
        mem_done <= 1'b1;
        m_rdata  <= mv(m_lat);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check(string n, logic [23:0] seen, logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  always @(posedge i_clk) begin
    if (adp_rv) begin
      if (q.size() == 0) check("unexpected_read", 24'h1, 24'h0);
      else check(q[0].n, adp_rdata & q[0].m, q[0].v);
      if (q.size() != 0) void'(q.pop_front());
    end
    if (m_wr) begin
      if (mq.size() == 0) check("unexpected_write", 24'h1, 24'h0);
      else check("mem_write", {m_addr, m_wdata}, mq.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link operations
  task automatic note(string n, dbgrs_byte_t v, dbgrs_byte_t m);
    q.push_back('{n, v & m, m});
  endtask : note

  task automatic wr_data(dbgrs_byte_t s, dbgrs_byte_t v);
    adp_u.frame(`DBGRS_INS_ADDR_WR, s);
    adp_u.frame(`DBGRS_INS_DATA_WR, v);
  endtask : wr_data

  task automatic rd_data(dbgrs_byte_t s, dbgrs_byte_t v, dbgrs_byte_t m);
    adp_u.frame(`DBGRS_INS_ADDR_WR, s);
    note($sformatf("data_%h", s), v, m);
    adp_u.frame(`DBGRS_INS_DATA_RD, 8'h00);
  endtask : rd_data

  task automatic poll();
    for (int i = 0; i < 200; i++) begin
      note("status_poll", 8'h00, 8'h7f);
      adp_u.frame(`DBGRS_INS_ADDR_RD, 8'h00);
      if (adp_rdata[`DBGRS_BUSY_BIT] === 1'b0) return;
    end
    failures++;
    summarize();
  endtask : poll

  initial begin
    #(25 * 90000);
    failures++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    dbgrs_byte_t sel[6], v, d, b;
    logic [15:0] a;
    logic [15:0] crc;
    sel = '{`DBGRS_SEL_HALT, `DBGRS_SEL_PROG_CTRL, `DBGRS_SEL_ADDR_HIGH,
            `DBGRS_SEL_ADDR_LOW, `DBGRS_SEL_CHK_TWO, `DBGRS_SEL_CHK_THREE};
    void'($urandom(32'h53111c05));
    i_reset = 1'b1;
    deny_q  = 1'b0;
    wl      = 1'b0;
    rl      = 1'b0;
    m_cnt   = 3'd0;
    m_rdata = 8'h00;
    checks  = 0;
    failures = 0;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    wl      <= 1'($urandom);
    rl      <= 1'($urandom);
    repeat (6) @(posedge i_clk);
    note("status_reset", 8'h00, 8'hff);
    adp_u.frame(`DBGRS_INS_ADDR_RD, 8'h00);
    note("id_reset_select", PID, 8'hff);
    adp_u.frame(`DBGRS_INS_DATA_RD, 8'h00);
    rd_data(`DBGRS_SEL_REVISION, REV, 8'hff);
    wr_data(`DBGRS_SEL_PART_ID, ~PID);
    rd_data(`DBGRS_SEL_PART_ID, PID, 8'hff);
    foreach (sel[i]) begin
      v = 8'($urandom);
      wr_data(sel[i], v);
      rd_data(sel[i], v, 8'hff);
      if (i == 0) check("halt_out", dut_u.o_halt_control, v);
      if (i == 1) check("prog_out", dut_u.o_prom_program_control, v);
    end
    wr_data(8'h55, 8'h3a);
    rd_data(8'h55, 8'h00, 8'hff);
    adp_u.bit_out(1'b0);
    adp_u.bit_out(1'b1);
    adp_u.bit_out(1'b1);
    adp_u.bit_out(1'b0);
    repeat (60) @(posedge i_clk);
    rd_data(`DBGRS_SEL_REVISION, REV, 8'hff);
    a = 16'($urandom) & 16'hfffe;
    d = 8'($urandom);
    wr_data(`DBGRS_SEL_ADDR_HIGH, a[15:8]);
    wr_data(`DBGRS_SEL_ADDR_LOW, a[7:0]);
    deny_q <= 1'($urandom);
    mq.push_back({a, d});
    wr_data(`DBGRS_SEL_DATA_PORT, d);
    poll();
    rd_data(`DBGRS_SEL_PROM_STATUS, {wl, rl, 5'b0, deny_q}, 8'hff);
    rd_data(`DBGRS_SEL_ADDR_LOW, a[7:0] + 8'h01, 8'hff);
    deny_q <= 1'b0;
    rd_data(`DBGRS_SEL_DATA_PORT, `DBGRS_BYTE_RESET, 8'hff);
    poll();
    rd_data(`DBGRS_SEL_DATA_PORT, mv(a + 16'h1), 8'hff);
    poll();
    b = 8'($urandom);
    crc = crc_ref(b);
    wr_data(`DBGRS_SEL_CHK_ZERO, b);
    note("status_busy", 8'h80, 8'h80);
    adp_u.frame(`DBGRS_INS_ADDR_RD, 8'h00);
    poll();
    rd_data(`DBGRS_SEL_CHK_ONE, crc[15:8], 8'hff);
    rd_data(`DBGRS_SEL_CHK_ZERO, crc[7:0], 8'hff);
    repeat (4) @(posedge i_clk);
    check("pending_notes", 24'(q.size() + mq.size()), 24'h0);
    summarize();
  end
endmodule : test_two_wire_debug_register_select
`default_nettype wire
